// ### iort_cfg.svh
// Offsets, field positions, codes and reset values of the I/O routing block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
// What this block does
// (R1) Rear monitor select: 8-bit code, 0..4.
// (R2) Rear monitor select reads back unchanged.
// (R3) Front output 1 enable routes ramp.
// (R4) Front output 1 enable reads back.
// (R5) Front output 2 enable gates chosen source.
// (R6) Front output 2 source: 8-bit code, 0..4.
// (R7) Front output 2 source reads back.
// (R8) Input A enable adds A to servo.
// (R9) Input B enable adds B to aux.
// (R10) Input A and B enables read back.
// (R11) Enable takes 1 or 0 only.
// (R12) Trigger in modes: none, servo, hold.
// (R13) Trigger in mode resets to zero.
// (R14) Hold toggles only while servo on.
// (R15) Trigger in mode: 16 bits, reads back.
// (R16) Trigger out mode: 16 bits, reads back.
// (R17) Out-of-range select codes leave old value.
// (R18) Each trigger rising edge toggles once.
`ifndef IORT_CFG_SVH
`define IORT_CFG_SVH
`define IORT_ADR_W 6
`define IORT_OFS_REAR 6'h00
`define IORT_OFS_FO1EN 6'h04
`define IORT_OFS_FO2EN 6'h08
`define IORT_OFS_FO2SRC 6'h0C
`define IORT_OFS_MODA 6'h10
`define IORT_OFS_MODB 6'h14
`define IORT_OFS_TRGIN 6'h18
`define IORT_OFS_TRGOUT 6'h1C
`define IORT_OFS_CTL 6'h20
`define IORT_CTL_SERVO 0
`define IORT_CTL_HOLD 1
`define IORT_CTL_TRIG 2
`define IORT_SEL_MAX 8'h04
`define IORT_EN_ON 8'h01
`define IORT_EN_OFF 8'h00
`define IORT_TMODE_NONE 16'h0000
`define IORT_TMODE_SERVO 16'h0001
`define IORT_TMODE_HOLD 16'h0002
`define IORT_RST_SEL 8'h00
`define IORT_RST_MODE 16'h0000
`endif

// ### iort_pkg.sv
// Types shared by the I/O routing block and its trigger edge detector.
// Assumes iort_cfg.svh is on the include path.
`include "iort_cfg.svh"
package iort_pkg;
  // Classic Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [`IORT_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } iort_wb_req_t;
  // Routing selections presented to the analogue switches.
  typedef struct packed {
    logic [7:0] rearMonSel;
    logic frontOut1On;
    logic [7:0] frontOut2Route;
    logic modAToServo;
    logic modBToAux;
    logic servoOn;
    logic sampleHoldOn;
    logic [15:0] trigOutMode;
  } iort_route_t;
  typedef enum logic {BUS_IDLE, BUS_ACK} iort_bus_t;
  // Whole state of the register block.
  typedef struct packed {
    iort_bus_t phase;
    logic [31:0] rdat;
    logic [7:0] rearMon;
    logic fo1En;
    logic fo2En;
    logic [7:0] fo2Src;
    logic [7:0] fo2Out;
    logic modA;
    logic modB;
    logic [15:0] trigInMode;
    logic [15:0] trigOutMode;
    logic servo;
    logic hold;
  } iort_state_t;
  // State of the trigger edge detector.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic rise;
  } iort_edge_t;
endpackage

// ### iort_trig_edge.sv
// Trigger input synchroniser and rising edge detector.
// Assumes a single clock; the trigger pin may change at any time.
`timescale 1ns/1ns
`default_nettype none
module iort_trig_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic trigIn,
  output logic trigLevel,
  output logic trigRise
);
  import iort_pkg::*;
  iort_edge_t st_q;
  iort_edge_t st_d;

  // Two-stage synchroniser, then a one-cycle pulse on each rising edge.
  always_comb begin
    st_d = st_q;
    st_d.sync1 = trigIn;
    st_d.sync2 = st_q.sync1;
    st_d.last = st_q.sync2;
    st_d.rise = st_q.sync2 & ~st_q.last; // R18
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign trigLevel = st_q.last;
  assign trigRise = st_q.rise;

  // A pulse never lasts two cycles, so one edge toggles only once.
  property p_rise_single;
    @(posedge clk) disable iff (rst) trigRise |=> !trigRise;
  endproperty
  a_rise_single: assert property (p_rise_single) else $error("trigger pulse too long"); // R18
endmodule
`default_nettype wire

// ### iort_io_routing.sv
// Register block holding output routing, modulation enables and trigger modes.
// Assumes a classic Wishbone master; the trigger pin may be asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "iort_cfg.svh"
module iort_io_routing (
  input wire logic clk,
  input wire logic rst,
  input wire iort_pkg::iort_wb_req_t wbReq,
  output logic wbAck,
  output logic [31:0] wbDatOut,
  input wire logic trigIn,
  output iort_pkg::iort_route_t route
);
  import iort_pkg::*;

  iort_state_t st_q;
  iort_state_t st_d;
  logic trigLevel;
  logic trigRise;
  logic access;
  logic wrEn;
  logic rdEn;
  logic ctlWrite;
  logic [31:0] wdat;

  // Merges the written byte lanes into the present register contents.
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Tells whether a selection code lies inside the defined range.
  function automatic logic selValid(input logic [7:0] code);
    return code <= `IORT_SEL_MAX;
  endfunction

  // Applies a 1 or 0 enable token, keeping the old state on anything else.
  function automatic logic enableArg(input logic old, input logic [7:0] arg);
    logic res;
    res = old;
    if (arg == `IORT_EN_ON) begin
      res = 1'b1;
    end else if (arg == `IORT_EN_OFF) begin
      res = 1'b0;
    end
    return res;
  endfunction

  // Trigger pin synchroniser and edge detector.
  iort_trig_edge u_trig (
    .clk(clk),
    .rst(rst),
    .trigIn(trigIn),
    .trigLevel(trigLevel),
    .trigRise(trigRise)
  );

  // A request is taken once per transfer, in the cycle before the ack.
  assign access = wbReq.cyc & wbReq.stb & (st_q.phase == BUS_IDLE);
  assign wrEn = access & wbReq.we;
  assign rdEn = access & ~wbReq.we;
  assign ctlWrite = wrEn & (wbReq.adr == `IORT_OFS_CTL);

  // Next state: bus handshake, register writes, read mux, trigger action.
  always_comb begin
    st_d = st_q;
    wdat = '0;
    st_d.phase = access ? BUS_ACK : BUS_IDLE;
    if (wrEn) begin
      case (wbReq.adr)
        `IORT_OFS_REAR: begin
          wdat = mergeBytes({24'h000000, st_q.rearMon}, wbReq.dat, wbReq.sel);
          if (selValid(wdat[7:0])) begin // R17
            st_d.rearMon = wdat[7:0]; // R1
          end
        end
        `IORT_OFS_FO1EN: begin
          wdat = mergeBytes({31'h00000000, st_q.fo1En}, wbReq.dat, wbReq.sel);
          st_d.fo1En = enableArg(st_q.fo1En, wdat[7:0]); // R11
        end
        `IORT_OFS_FO2EN: begin
          wdat = mergeBytes({31'h00000000, st_q.fo2En}, wbReq.dat, wbReq.sel);
          st_d.fo2En = enableArg(st_q.fo2En, wdat[7:0]); // R11
        end
        `IORT_OFS_FO2SRC: begin
          wdat = mergeBytes({24'h000000, st_q.fo2Src}, wbReq.dat, wbReq.sel);
          if (selValid(wdat[7:0])) begin // R17
            st_d.fo2Src = wdat[7:0]; // R6
          end
        end
        `IORT_OFS_MODA: begin
          wdat = mergeBytes({31'h00000000, st_q.modA}, wbReq.dat, wbReq.sel);
          st_d.modA = enableArg(st_q.modA, wdat[7:0]); // R11
        end
        `IORT_OFS_MODB: begin
          wdat = mergeBytes({31'h00000000, st_q.modB}, wbReq.dat, wbReq.sel);
          st_d.modB = enableArg(st_q.modB, wdat[7:0]); // R11
        end
        `IORT_OFS_TRGIN: begin
          wdat = mergeBytes({16'h0000, st_q.trigInMode}, wbReq.dat, wbReq.sel);
          st_d.trigInMode = wdat[15:0]; // R15
        end
        `IORT_OFS_TRGOUT: begin
          wdat = mergeBytes({16'h0000, st_q.trigOutMode}, wbReq.dat, wbReq.sel);
          st_d.trigOutMode = wdat[15:0]; // R16
        end
        `IORT_OFS_CTL: begin
          if (wbReq.sel[0]) begin
            st_d.servo = wbReq.dat[`IORT_CTL_SERVO];
            st_d.hold = wbReq.dat[`IORT_CTL_HOLD];
          end
        end
        default: begin
          wdat = '0;
        end
      endcase
    end
    // The trigger acts on top of a same-cycle software write, so no edge is lost.
    if (trigRise) begin
      case (st_q.trigInMode)
        `IORT_TMODE_SERVO: begin
          st_d.servo = ~st_d.servo; // R12 R18
        end
        `IORT_TMODE_HOLD: begin
          if (st_d.servo) begin // R14
            st_d.hold = ~st_d.hold; // R18
          end
        end
        default: begin
          st_d.servo = st_d.servo; // R12
        end
      endcase
    end
    // Output 2 carries its chosen source only while enabled.
    st_d.fo2Out = st_d.fo2En ? st_d.fo2Src : `IORT_RST_SEL; // R5
    // Read data, zero for unmapped offsets.
    st_d.rdat = '0;
    if (rdEn) begin
      case (wbReq.adr)
        `IORT_OFS_REAR: st_d.rdat = {24'h000000, st_q.rearMon}; // R2
        `IORT_OFS_FO1EN: st_d.rdat = {31'h00000000, st_q.fo1En}; // R4
        `IORT_OFS_FO2EN: st_d.rdat = {31'h00000000, st_q.fo2En};
        `IORT_OFS_FO2SRC: st_d.rdat = {24'h000000, st_q.fo2Src}; // R7
        `IORT_OFS_MODA: st_d.rdat = {31'h00000000, st_q.modA}; // R10
        `IORT_OFS_MODB: st_d.rdat = {31'h00000000, st_q.modB}; // R10
        `IORT_OFS_TRGIN: st_d.rdat = {16'h0000, st_q.trigInMode}; // R15
        `IORT_OFS_TRGOUT: st_d.rdat = {16'h0000, st_q.trigOutMode}; // R16
        `IORT_OFS_CTL: begin
          st_d.rdat[`IORT_CTL_SERVO] = st_q.servo;
          st_d.rdat[`IORT_CTL_HOLD] = st_q.hold;
          st_d.rdat[`IORT_CTL_TRIG] = trigLevel;
        end
        default: st_d.rdat = '0;
      endcase
    end
  end

  // State register; all selections and modes start at zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.trigInMode <= `IORT_RST_MODE; // R13
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign wbAck = (st_q.phase == BUS_ACK);
  assign wbDatOut = st_q.rdat;
  assign route.rearMonSel = st_q.rearMon;
  assign route.frontOut1On = st_q.fo1En; // R3
  assign route.frontOut2Route = st_q.fo2Out;
  assign route.modAToServo = st_q.modA; // R8
  assign route.modBToAux = st_q.modB; // R9
  assign route.servoOn = st_q.servo;
  assign route.sampleHoldOn = st_q.hold;
  assign route.trigOutMode = st_q.trigOutMode;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Each taken request is answered one cycle later for one cycle.
  property p_bus_ack;
    access |=> wbAck ##1 !wbAck;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("ack not one cycle after request");

  // A valid rear code written is held from the next cycle.
  property p_rear_write;
    (wrEn && wbReq.adr == `IORT_OFS_REAR && wbReq.sel[0] && wbReq.dat[7:0] <= `IORT_SEL_MAX)
      |=> route.rearMonSel == $past(wbReq.dat[7:0]);
  endproperty
  a_rear_write: assert property (p_rear_write) else $error("rear code not stored"); // R1

  // An out-of-range code leaves both selections as they were.
  property p_sel_reject;
    (wrEn && wbReq.sel[0] && wbReq.dat[7:0] > `IORT_SEL_MAX &&
      (wbReq.adr == `IORT_OFS_REAR || wbReq.adr == `IORT_OFS_FO2SRC))
      |=> $stable(st_q.rearMon) && $stable(st_q.fo2Src);
  endproperty
  a_sel_reject: assert property (p_sel_reject) else $error("bad code accepted"); // R17

  // A read of the rear selection returns the held code with the ack.
  property p_rear_read;
    (rdEn && wbReq.adr == `IORT_OFS_REAR) |=> wbDatOut == {24'h000000, route.rearMonSel};
  endproperty
  a_rear_read: assert property (p_rear_read) else $error("rear readback wrong"); // R2

  // Output 2 follows the source once enabled and is silent when disabled.
  property p_fo2_gate;
    route.frontOut2Route == (st_q.fo2En ? st_q.fo2Src : 8'h00);
  endproperty
  a_fo2_gate: assert property (p_fo2_gate) else $error("output 2 gating wrong"); // R5

  // An output 1 enable write other than 1 or 0 changes nothing.
  property p_en_token;
    (wrEn && wbReq.adr == `IORT_OFS_FO1EN && wbReq.sel[0] && wbReq.dat[7:0] > 8'h01)
      |=> $stable(route.frontOut1On);
  endproperty
  a_en_token: assert property (p_en_token) else $error("bad enable token taken"); // R11

  // In servo mode each edge inverts the servo state once.
  property p_servo_toggle;
    (trigRise && st_q.trigInMode == `IORT_TMODE_SERVO && !ctlWrite)
      |=> route.servoOn != $past(route.servoOn);
  endproperty
  a_servo_toggle: assert property (p_servo_toggle) else $error("servo not toggled"); // R18

  // In hold mode nothing happens while the servo is off.
  property p_hold_gated;
    (trigRise && st_q.trigInMode == `IORT_TMODE_HOLD && !st_q.servo && !ctlWrite)
      |=> $stable(route.sampleHoldOn) && !route.servoOn;
  endproperty
  a_hold_gated: assert property (p_hold_gated) else $error("hold toggled with servo off"); // R14

  // In mode zero an edge has no effect.
  property p_mode_none;
    (trigRise && st_q.trigInMode == `IORT_TMODE_NONE && !ctlWrite)
      |=> $stable(route.servoOn) && $stable(route.sampleHoldOn);
  endproperty
  a_mode_none: assert property (p_mode_none) else $error("mode zero acted"); // R12

  // Writing the on token to output 1 routes the ramp from the next cycle.
  property p_fo1_on;
    (wrEn && wbReq.adr == `IORT_OFS_FO1EN && wbReq.sel[0] && wbReq.dat[7:0] == `IORT_EN_ON)
      |=> route.frontOut1On;
  endproperty
  a_fo1_on: assert property (p_fo1_on) else $error("output 1 not enabled"); // R3

  // Writing the off token to output 1 silences it from the next cycle.
  property p_fo1_off;
    (wrEn && wbReq.adr == `IORT_OFS_FO1EN && wbReq.sel[0] && wbReq.dat[7:0] == `IORT_EN_OFF)
      |=> !route.frontOut1On;
  endproperty
  a_fo1_off: assert property (p_fo1_off) else $error("output 1 not disabled"); // R11

  // A read of the output 1 enable returns the held state.
  property p_fo1_read;
    (rdEn && wbReq.adr == `IORT_OFS_FO1EN) |=> wbDatOut == {31'h0, route.frontOut1On};
  endproperty
  a_fo1_read: assert property (p_fo1_read) else $error("output 1 readback wrong"); // R4

  // A valid source code written is held from the next cycle.
  property p_src_write;
    (wrEn && wbReq.adr == `IORT_OFS_FO2SRC && wbReq.sel[0] && wbReq.dat[7:0] <= `IORT_SEL_MAX)
      |=> st_q.fo2Src == $past(wbReq.dat[7:0]);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source code not stored"); // R6

  // A read of the output 2 source returns the held code.
  property p_src_read;
    (rdEn && wbReq.adr == `IORT_OFS_FO2SRC) |=> wbDatOut == {24'h000000, st_q.fo2Src};
  endproperty
  a_src_read: assert property (p_src_read) else $error("source readback wrong"); // R7

  // Writing the on token to input A adds it to the servo output.
  property p_moda_on;
    (wrEn && wbReq.adr == `IORT_OFS_MODA && wbReq.sel[0] && wbReq.dat[7:0] == `IORT_EN_ON)
      |=> route.modAToServo;
  endproperty
  a_moda_on: assert property (p_moda_on) else $error("input A not enabled"); // R8

  // Writing the on token to input B adds it to the aux output.
  property p_modb_on;
    (wrEn && wbReq.adr == `IORT_OFS_MODB && wbReq.sel[0] && wbReq.dat[7:0] == `IORT_EN_ON)
      |=> route.modBToAux;
  endproperty
  a_modb_on: assert property (p_modb_on) else $error("input B not enabled"); // R9

  // A read of the input A enable returns the held state.
  property p_moda_read;
    (rdEn && wbReq.adr == `IORT_OFS_MODA) |=> wbDatOut == {31'h0, route.modAToServo};
  endproperty
  a_moda_read: assert property (p_moda_read) else $error("input A readback wrong"); // R10

  // A read of the input B enable returns the held state.
  property p_modb_read;
    (rdEn && wbReq.adr == `IORT_OFS_MODB) |=> wbDatOut == {31'h0, route.modBToAux};
  endproperty
  a_modb_read: assert property (p_modb_read) else $error("input B readback wrong"); // R10

  // A full-width trigger in mode write is held from the next cycle.
  property p_trgin_write;
    (wrEn && wbReq.adr == `IORT_OFS_TRGIN && wbReq.sel[1:0] == 2'h3)
      |=> st_q.trigInMode == $past(wbReq.dat[15:0]);
  endproperty
  a_trgin_write: assert property (p_trgin_write) else $error("trigger in mode not stored"); // R15

  // A read of the trigger in mode returns the held mode.
  property p_trgin_read;
    (rdEn && wbReq.adr == `IORT_OFS_TRGIN) |=> wbDatOut == {16'h0000, st_q.trigInMode};
  endproperty
  a_trgin_read: assert property (p_trgin_read) else $error("trigger in readback wrong"); // R15

  // A read of the trigger out mode returns the presented mode.
  property p_trgout_read;
    (rdEn && wbReq.adr == `IORT_OFS_TRGOUT) |=> wbDatOut == {16'h0000, route.trigOutMode};
  endproperty
  a_trgout_read: assert property (p_trgout_read) else $error("trigger out readback wrong"); // R16

  // In hold mode with the servo on, each edge inverts the hold state once.
  property p_hold_toggle;
    (trigRise && st_q.trigInMode == `IORT_TMODE_HOLD && st_q.servo && !ctlWrite)
      |=> route.sampleHoldOn != $past(route.sampleHoldOn);
  endproperty
  a_hold_toggle: assert property (p_hold_toggle) else $error("hold not toggled"); // R14

  // Main scenarios.
  c_rear_write: cover property (wrEn && wbReq.adr == `IORT_OFS_REAR);
  c_servo_toggle: cover property (trigRise && st_q.trigInMode == `IORT_TMODE_SERVO);
  c_hold_toggle: cover property (trigRise && st_q.trigInMode == `IORT_TMODE_HOLD && st_q.servo);
  c_read: cover property (rdEn ##1 wbAck);
  c_sel_reject: cover property (wrEn && wbReq.adr == `IORT_OFS_FO2SRC && wbReq.dat[7:0] > 8'h04);
endmodule
`default_nettype wire

// ### iort_host_model.sv
// Host model that issues configuration requests over classic Wishbone.
// Assumes the slave acks every request it takes within a few cycles.
`timescale 1ns/1ns
`default_nettype none
module iort_host_model (
  input wire logic clk,
  output var iort_pkg::iort_wb_req_t wbReq,
  input wire logic wbAck,
  input wire logic [31:0] wbDatOut
);
  import iort_pkg::*;
  // The bus idles with every request line low.
  initial begin
    wbReq = '0;
  end
  // One classic cycle: hold the request until ack is sampled, then idle a cycle.
  task automatic access(input logic w, input logic [5:0] a, input logic [31:0] d,
      output logic [31:0] q, output bit ok);
    int n;
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 40);
    ok = (wbAck === 1'b1);
    q = wbDatOut;
    wbReq <= '0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench of the routing block against a register model.
// Assumes the block answers each request and routes from its registers.
`timescale 1ns/1ns
`default_nettype none
`include "iort_cfg.svh"
module tb;
  import iort_pkg::*;
  logic clk;
  logic rst;
  logic trigIn;
  iort_wb_req_t wbReq;
  logic wbAck;
  logic [31:0] wbDatOut;
  iort_route_t route;
  int failures;
  int cmpCount;
  int seed;
  int mdl [16];

  iort_io_routing u_iort_io_routing (.clk(clk), .rst(rst), .wbReq(wbReq), .wbAck(wbAck),
    .wbDatOut(wbDatOut), .trigIn(trigIn), .route(route));
  iort_host_model u_iort_host_model (.clk(clk), .wbReq(wbReq), .wbAck(wbAck),
    .wbDatOut(wbDatOut));

  // Free-running system clock of 100 ns.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Reports the counts and the verdict, then stops.
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value with its expectation.
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Writes a register and applies the same write to the model.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bit ok;
    int i;
    u_iort_host_model.access(1'b1, a, d, q, ok);
    if (!ok) begin
      failures++;
      finish_test();
    end
    i = a[5:2];
    case (i)
      0, 3: if (d <= 32'h4) mdl[i] = d;
      1, 2, 4, 5: if (d <= 32'h1) mdl[i] = d;
      6, 7: mdl[i] = d[15:0];
      8: mdl[i] = d[1:0];
      default: ;
    endcase
  endtask

  // Reads a register and compares it and the whole routing with the model.
  task automatic rd_chk(input logic [5:0] a);
    logic [31:0] q;
    bit ok;
    logic [31:0] e;
    iort_route_t r;
    u_iort_host_model.access(1'b0, a, 32'h0, q, ok);
    if (!ok) begin
      failures++;
      finish_test();
    end
    e = (a[5:2] <= 4'h8 && a[1:0] == 2'h0) ? 32'(mdl[a[5:2]]) : 32'h0;
    check("read data", q, e);
    r.rearMonSel = mdl[0][7:0];
    r.frontOut1On = mdl[1][0];
    r.frontOut2Route = mdl[2][0] ? mdl[3][7:0] : 8'h00;
    r.modAToServo = mdl[4][0];
    r.modBToAux = mdl[5][0];
    r.servoOn = mdl[8][0];
    r.sampleHoldOn = mdl[8][1];
    r.trigOutMode = mdl[7][15:0];
    check("route", 64'(route), 64'(r));
  endtask

  // One trigger pulse; the model toggles as the held mode dictates.
  task automatic pulse();
    trigIn <= 1'b1;
    repeat (3) @(posedge clk);
    trigIn <= 1'b0;
    repeat (6) @(posedge clk);
    if (mdl[6] == 1) mdl[8] ^= 1;
    else if (mdl[6] == 2 && mdl[8][0]) mdl[8] ^= 2;
  endtask

  // Main sequence: reset, selections, enables, modes and trigger actions.
  initial begin
    seed = 40;
    failures = 0;
    cmpCount = 0;
    rst = 1'b1;
    trigIn = 1'b0;
    foreach (mdl[i]) mdl[i] = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) rd_chk(6'(i * 4));
    for (int c = 0; c < 5; c++) begin
      wr(`IORT_OFS_REAR, 32'(c));
      rd_chk(`IORT_OFS_REAR);
    end
    wr(`IORT_OFS_REAR, 32'h5 + ({$random(seed)} % 251));
    rd_chk(`IORT_OFS_REAR);
    wr(`IORT_OFS_FO2EN, `IORT_EN_ON);
    for (int c = 0; c < 6; c++) begin
      wr(`IORT_OFS_FO2SRC, (c == 5) ? 32'hFF : 32'(c));
      rd_chk(`IORT_OFS_FO2SRC);
    end
    wr(`IORT_OFS_FO2EN, `IORT_EN_OFF);
    rd_chk(`IORT_OFS_FO2EN);
    for (int k = 0; k < 4; k++) begin
      wr(6'((k < 2) ? 4 + 4 * k : 8 + 4 * k), `IORT_EN_ON);
      rd_chk(6'((k < 2) ? 4 + 4 * k : 8 + 4 * k));
      wr(6'((k < 2) ? 4 + 4 * k : 8 + 4 * k), 32'h2 + ({$random(seed)} % 254));
      rd_chk(6'((k < 2) ? 4 + 4 * k : 8 + 4 * k));
      wr(6'((k < 2) ? 4 + 4 * k : 8 + 4 * k), `IORT_EN_OFF);
      rd_chk(6'((k < 2) ? 4 + 4 * k : 8 + 4 * k));
    end
    repeat (3) begin
      wr(`IORT_OFS_TRGOUT, $random(seed));
      rd_chk(`IORT_OFS_TRGOUT);
    end
    pulse();
    rd_chk(`IORT_OFS_CTL);
    wr(`IORT_OFS_TRGIN, `IORT_TMODE_SERVO);
    pulse();
    rd_chk(`IORT_OFS_CTL);
    pulse();
    rd_chk(`IORT_OFS_CTL);
    wr(`IORT_OFS_TRGIN, `IORT_TMODE_HOLD);
    wr(`IORT_OFS_CTL, 32'h0);
    pulse();
    rd_chk(`IORT_OFS_CTL);
    wr(`IORT_OFS_CTL, 32'h1);
    pulse();
    rd_chk(`IORT_OFS_CTL);
    pulse();
    rd_chk(`IORT_OFS_CTL);
    wr(`IORT_OFS_TRGIN, 32'h12345);
    rd_chk(`IORT_OFS_TRGIN);
    pulse();
    rd_chk(`IORT_OFS_CTL);
    wr(6'h30, $random(seed));
    rd_chk(6'h30);
    finish_test();
  end
endmodule
`default_nettype wire
